// ==== hw/digital_output_delay_conditioner.sv ====
// Two-channel extension digital output conditioner with AHB-Lite settings
//
// Overview of operation
// - Output asserts only after full turn-on delay
// - Output releases only after hold delay
// - Fault or mains source forces zero on-delay
// - Polarity selects output level when source true
// - Locked sources force active-high polarity
// - Locked sources force zero hold delay
// - Factory reset clears both delays
// - Second channel behaves like the first
// - Channels work only with board present
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "dout_cond_map.svh"

module digital_output_delay_conditioner #(
	parameter int unsigned TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
	parameter int unsigned NSRC        = 64
) (
	input  wire logic            ref_clk,
	input  wire logic            rst_n,
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic      [31:0]     hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	input  wire logic [NSRC-1:0] sources,
	input  wire logic            board_present,
	input  wire logic            factory_reset,
	output logic                 ext_output_a,
	output logic                 ext_output_b
);

	typedef struct packed {
		logic       src_neg;
		logic [5:0] src;
		logic [15:0] on_ms;
		logic [13:0] hold_ms;
	} cfg_s;

	typedef struct packed {
		logic            wr_pend;
		logic [5:0]      wr_idx;
		logic [31:0]     rdata;
		logic [NSRC-1:0] src_s1;
		logic [NSRC-1:0] src_s2;
		logic [1:0]  pres;
		logic [1:0]  frst;
		cfg_s [1:0]  cfg;
	} top_s;

	top_s state_reg;
	top_s state_next;
	logic [1:0] rst_sync_reg;
	logic rst_sync_n;
	logic tick;
	logic [1:0] chan_out;
	logic [1:0] chan_act;
	logic [1:0] chan_src;

	// ==============================================================
	// Helpers
	function automatic logic is_locked(input logic [5:0] s);
		is_locked = (s >= 6'(dout_cond_pkg::SRC_FAULT)) &&
			(s <= 6'(dout_cond_pkg::SRC_PUMP6));
	endfunction : is_locked

	function automatic logic is_zero_on(input logic [5:0] s);
		is_zero_on = (s == 6'(dout_cond_pkg::SRC_FAULT)) ||
			(s == 6'(dout_cond_pkg::SRC_MAINS));
	endfunction : is_zero_on

	function automatic logic hits(input logic [5:0] idx, input logic [7:0] off);
		hits = (idx == off[`ADDR_IDX_MSB:`ADDR_IDX_LSB]);
	endfunction : hits

	// Apply source-driven locks on every write so forced fields never hold stale values
	function automatic cfg_s apply_write(input logic [31:0] w);
		cfg_s c;
		logic [15:0] on_v;
		logic [7:0]  hold_v;
		c.src = w[`CFG_SRC_LSB +: `CFG_SRC_W];
		on_v = w[`CFG_ON_LSB +: `CFG_ON_W];
		hold_v = w[`CFG_HOLD_LSB +: `CFG_HOLD_W];
		c.on_ms = (on_v > `ON_DELAY_MAX_MS) ? `ON_DELAY_MAX_MS : on_v;
		c.hold_ms = 14'(hold_v) * `HOLD_UNIT_MS;
		if (c.hold_ms > `HOLD_MAX_MS)
			c.hold_ms = `HOLD_MAX_MS;
		c.src_neg = w[`CFG_NEG_BIT];
		if (is_zero_on(c.src))
			c.on_ms = `DELAY_RESET;
		if (is_locked(c.src))
		begin
			c.src_neg = 1'b0;
			c.hold_ms = 14'h0000;
		end
		apply_write = c;
	endfunction : apply_write

	function automatic logic [31:0] pack_cfg(input cfg_s c);
		logic [31:0] w;
		w = 32'h00000000;
		w[`CFG_SRC_LSB +: `CFG_SRC_W] = c.src;
		w[`CFG_NEG_BIT] = c.src_neg;
		w[`CFG_ON_LSB +: `CFG_ON_W] = c.on_ms;
		w[`CFG_HOLD_LSB +: `CFG_HOLD_W] = 8'(c.hold_ms / `HOLD_UNIT_MS);
		pack_cfg = w;
	endfunction : pack_cfg

	// ==============================================================
	// Bus and settings
	always_comb
	begin
		logic take;
		logic [5:0] idx;
		take = 1'b0;
		idx = 6'h00;
		state_next = state_reg;
		// Every source is synchronised before the selector reads it
		state_next.src_s1 = sources;
		state_next.src_s2 = state_reg.src_s1;
		state_next.pres = {state_reg.pres[0], board_present};
		state_next.frst = {state_reg.frst[0], factory_reset};
		take = hsel && hready && htrans[1];
		idx = haddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
		state_next.wr_pend = take && hwrite;
		if (take)
			state_next.wr_idx = idx;
		if (state_reg.wr_pend)
		begin
			if (hits(state_reg.wr_idx, `OFF_CFG_A))
				state_next.cfg[0] = apply_write(hwdata);
			else if (hits(state_reg.wr_idx, `OFF_CFG_B))
				state_next.cfg[1] = apply_write(hwdata);
		end
		if (take && !hwrite)
		begin
			if (hits(idx, `OFF_CFG_A))
				state_next.rdata = pack_cfg(state_reg.cfg[0]);
			else if (hits(idx, `OFF_CFG_B))
				state_next.rdata = pack_cfg(state_reg.cfg[1]);
			else if (hits(idx, `OFF_STATUS))
				state_next.rdata = {27'h0000000, state_reg.pres[1], chan_act, chan_out};
			else
				state_next.rdata = 32'h00000000;
		end
		if (state_reg.frst[1])
		begin
			state_next.cfg[0].on_ms = `DELAY_RESET;
			state_next.cfg[1].on_ms = `DELAY_RESET;
			state_next.cfg[0].hold_ms = 14'h0000;
			state_next.cfg[1].hold_ms = 14'h0000;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	// Rest of the state runs on the released reset copy
	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign rst_sync_n = rst_sync_reg[1];
	assign hrdata = state_reg.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ==============================================================
	// Channels
	ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.ref_clk (ref_clk),
		.rst_n   (rst_sync_n),
		.tick    (tick)
	);

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_chan
			assign chan_src[g] = state_reg.src_s2[state_reg.cfg[g].src];
			dout_chan u_chan (
				.ref_clk   (ref_clk),
				.rst_n     (rst_sync_n),
				.tick      (tick),
				.enable    (state_reg.pres[1]),
				.src_level (chan_src[g]),
				.on_ms     (state_reg.cfg[g].on_ms),
				.hold_ms   (state_reg.cfg[g].hold_ms),
				.neg       (state_reg.cfg[g].src_neg),
				.dout      (chan_out[g]),
				.active    (chan_act[g])
			);
		end
	endgenerate

	assign ext_output_a = chan_out[0];
	assign ext_output_b = chan_out[1];

endmodule : digital_output_delay_conditioner

// ==== hw/dout_cond_map.svh ====
// Register offsets, field positions, reset values and timing constants for the output conditioner
`ifndef DOUT_COND_MAP_SVH
`define DOUT_COND_MAP_SVH

// ==============================================================
// Register byte offsets
`define OFF_CFG_A        8'h00
`define OFF_CFG_B        8'h04
`define OFF_STATUS       8'h08

// ==============================================================
// Configuration register fields
`define CFG_SRC_LSB      0
`define CFG_SRC_W        6
`define CFG_NEG_BIT      7
`define CFG_ON_LSB       8
`define CFG_ON_W         16
`define CFG_HOLD_LSB     24
`define CFG_HOLD_W       8

// ==============================================================
// Limits and reset values
`define ON_DELAY_MAX_MS  16'hEA60
`define HOLD_MAX_MS      14'h270F
`define HOLD_UNIT_MS     14'h0028
`define DELAY_RESET      16'h0000
`define ADDR_IDX_LSB     2
`define ADDR_IDX_MSB     7

// ==============================================================
// Timing
`define TICK_PERIOD_NS   1000000
`define CLK_PERIOD_NS    8

`endif

// ==== hw/dout_cond_pkg.sv ====
// Types shared by the output conditioner files
package dout_cond_pkg;

	// ==============================================================
	// Source selection codes
	typedef enum logic [5:0] {
		SRC_NONE      = 6'h00,
		SRC_FAULT     = 6'h01,
		SRC_MAINS     = 6'h02,
		SRC_PRIMING   = 6'h03,
		SRC_JOCKEY    = 6'h04,
		SRC_PUMP1     = 6'h05,
		SRC_PUMP2     = 6'h06,
		SRC_PUMP3     = 6'h07,
		SRC_PUMP4     = 6'h08,
		SRC_PUMP5     = 6'h09,
		SRC_PUMP6     = 6'h0A
	} src_sel_e;

	typedef enum {
		ST_IDLE,
		ST_ON_WAIT,
		ST_ACTIVE,
		ST_HOLD_WAIT
	} chan_state_e;

endpackage : dout_cond_pkg

// ==== hw/ms_tick_gen.sv ====
// Millisecond tick generator
`timescale 1ns/100ps
`include "dout_cond_map.svh"

module ms_tick_gen #(
	parameter int unsigned TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	output logic      tick
);

	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} tick_s;

	tick_s state_reg;
	tick_s state_next;

	// ==============================================================
	// Counter
	always_comb
	begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (state_reg.cnt >= 32'(TICK_CYCLES - 1))
		begin
			state_next.cnt = 32'h00000000;
			state_next.tick = 1'b1;
		end
		else
		begin
			state_next.cnt = state_reg.cnt + 32'h00000001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign tick = state_reg.tick;

endmodule : ms_tick_gen

// ==== hw/dout_chan.sv ====
// One conditioned output channel: on delay, hold delay, polarity
`timescale 1ns/100ps
`include "dout_cond_map.svh"

module dout_chan (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        tick,
	input  wire logic        enable,
	input  wire logic        src_level,
	input  wire logic [15:0] on_ms,
	input  wire logic [13:0] hold_ms,
	input  wire logic        neg,
	output logic             dout,
	output logic             active
);

	typedef struct packed {
		dout_cond_pkg::chan_state_e st;
		logic [15:0]                cnt;
		logic                       dout;
	} chan_s;

	chan_s state_reg;
	chan_s state_next;

	// ==============================================================
	// Helpers
	// A nonzero wait needs one tick beyond its count, as the first tick may land at once
	function automatic logic elapsed(input logic [15:0] cnt, input logic [15:0] lim);
		elapsed = (lim == `DELAY_RESET) || (cnt > lim);
	endfunction : elapsed

	// ==============================================================
	// Delay state machine
	always_comb
	begin
		logic on_now;
		on_now = 1'b0;
		state_next = state_reg;
		unique case (state_reg.st)
			dout_cond_pkg::ST_IDLE:
				if (src_level)
				begin
					state_next.st = dout_cond_pkg::ST_ON_WAIT;
					state_next.cnt = `DELAY_RESET;
				end
			dout_cond_pkg::ST_ON_WAIT:
				if (!src_level)
					state_next.st = dout_cond_pkg::ST_IDLE;
				else if (elapsed(state_reg.cnt, on_ms))
					state_next.st = dout_cond_pkg::ST_ACTIVE;
				else if (tick)
					state_next.cnt = state_reg.cnt + 16'h0001;
			dout_cond_pkg::ST_ACTIVE:
				if (!src_level)
				begin
					state_next.st = dout_cond_pkg::ST_HOLD_WAIT;
					state_next.cnt = `DELAY_RESET;
				end
			dout_cond_pkg::ST_HOLD_WAIT:
				if (src_level)
					state_next.st = dout_cond_pkg::ST_ACTIVE;
				else if (elapsed(state_reg.cnt, {2'b00, hold_ms}))
					state_next.st = dout_cond_pkg::ST_IDLE;
				else if (tick)
					state_next.cnt = state_reg.cnt + 16'h0001;
		endcase
		if (!enable)
			state_next.st = dout_cond_pkg::ST_IDLE;
		on_now = (state_next.st == dout_cond_pkg::ST_ACTIVE) ||
			(state_next.st == dout_cond_pkg::ST_HOLD_WAIT);
		// Board absent forces a quiet low output regardless of polarity
		state_next.dout = enable ? (on_now ^ neg) : 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_reg <= '{st: dout_cond_pkg::ST_IDLE, cnt: 16'h0000, dout: 1'b0};
		else
			state_reg <= state_next;
	end

	assign dout = state_reg.dout;
	assign active = (state_reg.st == dout_cond_pkg::ST_ACTIVE) ||
		(state_reg.st == dout_cond_pkg::ST_HOLD_WAIT);

endmodule : dout_chan

// ==== dv/digital_output_delay_conditioner_properties.sv ====
// Port-level assertions for the output conditioner
`timescale 1ns/100ps
module digital_output_delay_conditioner_properties (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        board_present,
	input wire logic        ext_output_a,
	input wire logic        ext_output_b
);
	// ==============================================================
	// Helpers
	logic rd_stat;
	logic rd_free;
	assign rd_stat = hsel && hready && htrans[1] && !hwrite && haddr == 32'h8;
	assign rd_free = hsel && hready && htrans[1] && !hwrite && haddr inside {[32'hC:32'hFC]};
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==============================================================
	// Properties
	property p_zero_wait;
		hreadyout;
	endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("wait state");
	property p_okay;
		!hresp;
	endproperty
	a_okay: assert property (p_okay) else $error("error response");
	property p_absent_a;
		!board_present [*5] |-> !ext_output_a;
	endproperty
	a_absent_a: assert property (p_absent_a) else $error("a driven, board absent");
	property p_absent_b;
		!board_present [*5] |-> !ext_output_b;
	endproperty
	a_absent_b: assert property (p_absent_b) else $error("b driven, board absent");
	property p_stat_board;
		$stable(board_present) [*8] ##0 rd_stat |=> hrdata[4] == $past(board_present);
	endproperty
	a_stat_board: assert property (p_stat_board) else $error("board bit");
	property p_stat_a;
		rd_stat && $stable(ext_output_a) |=> hrdata[0] == $past(ext_output_a);
	endproperty
	a_stat_a: assert property (p_stat_a) else $error("status a");
	property p_stat_b;
		rd_stat && $stable(ext_output_b) |=> hrdata[1] == $past(ext_output_b);
	endproperty
	a_stat_b: assert property (p_stat_b) else $error("status b");
	property p_free_zero;
		rd_free |=> hrdata == 32'h0;
	endproperty
	a_free_zero: assert property (p_free_zero) else $error("unmapped read");
	c_wr: cover property (hsel && htrans[1] && hwrite && haddr == 32'h0);
	c_rise_a: cover property ($rose(ext_output_a));
	c_rise_b: cover property ($rose(ext_output_b));
endmodule : digital_output_delay_conditioner_properties

bind digital_output_delay_conditioner digital_output_delay_conditioner_properties chk_i (
	.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
	.hresp, .board_present, .ext_output_a, .ext_output_b);

// ==== dv/digital_output_delay_conditioner_test.sv ====
// Self-checking bench for the output conditioner
`timescale 1ns/100ps
module digital_output_delay_conditioner_test;
	localparam int TK = 10;
	logic        ref_clk;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire         hready;
	logic [31:0] hrdata;
	logic        hresp;
	logic [63:0] src;
	logic        board;
	logic        frst;
	logic        out_a;
	logic        out_b;
	logic [31:0] rd;
	int          errors;
	int          tests_run;
	digital_output_delay_conditioner #(.TICK_CYCLES(TK)) dut (
		.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hrdata, .hreadyout(hready), .hresp, .sources(src), .board_present(board),
		.factory_reset(frst), .ext_output_a(out_a), .ext_output_b(out_b));
	// ==============================================================
	// Helpers
	function automatic logic [31:0] cfg(logic [5:0] s, logic n, logic [15:0] o, logic [7:0] h);
		return {h, o, n, 1'b0, s};
	endfunction : cfg
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= 2'h2;
		do @(posedge ref_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge ref_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	// Stay mode stops at the first differing cycle, wait mode at the first match
	task automatic obs(input logic b, input logic l, input logic stay, input int n, string m);
		repeat (n)
		begin
			@(posedge ref_clk);
			if (((b ? out_b : out_a) === l) ^ stay)
				break;
		end
		chk(32'(b ? out_b : out_a), 32'(l), m);
	endtask : obs
	task automatic conclude;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	// ==============================================================
	// Scenarios
	task automatic t_timing;
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h0, "cfg a reset");
		bus(1'b1, 32'h0, cfg(6'd20, 1'b0, 16'd3, 8'd0));
		src[20] <= 1'b1;
		obs(1'b0, 1'b0, 1'b1, 3 * TK, "on early");
		obs(1'b0, 1'b1, 1'b0, TK + 18, "on late");
		src[20] <= 1'b0;
		obs(1'b0, 1'b0, 1'b0, 8, "off");
		src[20] <= 1'b1;
		repeat (TK) @(posedge ref_clk);
		src[20] <= 1'b0;
		obs(1'b0, 1'b0, 1'b1, 4 * TK, "revert");
		bus(1'b1, 32'h0, cfg(6'd20, 1'b0, 16'd0, 8'd2));
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, cfg(6'd20, 1'b0, 16'd0, 8'd2), "hold rb");
		src[20] <= 1'b1;
		obs(1'b0, 1'b1, 1'b0, TK + 8, "zero on");
		src[20] <= 1'b0;
		obs(1'b0, 1'b1, 1'b1, 80 * TK, "hold early");
		obs(1'b0, 1'b0, 1'b0, 4 * TK, "hold late");
		$display("timing done");
	endtask : t_timing
	task automatic t_fields;
		bus(1'b1, 32'h4, cfg(6'd20, 1'b0, 16'hFFFF, 8'hFF));
		bus(1'b0, 32'h4, 32'h0);
		chk(rd, cfg(6'd20, 1'b0, 16'hEA60, 8'hF9), "clamp");
		for (logic [5:0] c = 6'h01; c <= 6'h0A; c++)
		begin
			bus(1'b1, 32'h4, cfg(c, 1'b1, 16'd7, 8'd3));
			bus(1'b0, 32'h4, 32'h0);
			chk(rd, cfg(c, 1'b0, c < 6'h03 ? 16'd0 : 16'd7, 8'd0), "lock");
		end
		bus(1'b1, 32'hC, 32'hFFFFFFFF);
		bus(1'b0, 32'hC, 32'h0);
		chk(rd, 32'h0, "unmapped");
		$display("fields done");
	endtask : t_fields
	task automatic t_pol_board;
		bus(1'b1, 32'h4, cfg(6'd30, 1'b1, 16'd0, 8'd0));
		obs(1'b1, 1'b1, 1'b0, 8, "neg idle");
		src[30] <= 1'b1;
		obs(1'b1, 1'b0, 1'b0, TK + 8, "neg act");
		bus(1'b0, 32'h8, 32'h0);
		chk(rd[4:0], 5'h18, "status");
		src[30] <= 1'b0;
		obs(1'b1, 1'b1, 1'b0, TK + 8, "neg rel");
		board <= 1'b0;
		obs(1'b1, 1'b0, 1'b0, 8, "absent");
		bus(1'b0, 32'h8, 32'h0);
		chk(32'(rd[4]), 32'h0, "absent bit");
		board <= 1'b1;
		obs(1'b1, 1'b1, 1'b0, 8, "present");
		$display("polarity done");
	endtask : t_pol_board
	task automatic t_factory;
		bus(1'b1, 32'h0, cfg(6'd20, 1'b0, 16'd500, 8'd5));
		frst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		src[20] <= 1'b1;
		obs(1'b0, 1'b1, 1'b0, TK + 8, "fr on");
		src[20] <= 1'b0;
		obs(1'b0, 1'b0, 1'b0, TK + 8, "fr off");
		frst <= 1'b0;
		$display("factory done");
	endtask : t_factory
	// ==============================================================
	// Sequence
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		conclude();
	end
	initial
	begin
		{rst_n, hsel, haddr, htrans, hwrite, hsize, hwdata, src, frst} = '0;
		board = 1'b1;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_timing();
		t_fields();
		t_pol_board();
		t_factory();
		conclude();
	end
endmodule : digital_output_delay_conditioner_test
